// File: verilog/supervisor_pkg.sv
// shared constants, timing figures and state encoding of the supervisor
package supervisor_pkg;

  // ------------------------------------------------------------------
  // clock and timing figures
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_PER_MS = 1000;
  localparam int unsigned NS_PER_S = 1_000_000_000;
  localparam int unsigned STRETCH_MS = 200;
  localparam int unsigned WDOG_TIMEOUT_MS = 1600;
  localparam int unsigned KICK_PULSE_NS = 50;
  localparam int unsigned TIMER_W = 27;

  // shortest kick pulse in cycles, rounded down, never below one
  localparam longint unsigned KICK_PULSE_RAW =
    longint'(KICK_PULSE_NS) * longint'(CLK_HZ) / longint'(NS_PER_S);
  localparam int unsigned KICK_PULSE_CYCLES =
    (KICK_PULSE_RAW < 1) ? 1 : int'(KICK_PULSE_RAW);

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic RESET_ACTIVE_RST = 1'b1;
  localparam logic WDO_N_RST = 1'b1;
  localparam logic PFO_N_RST = 1'b1;
  localparam logic KICK_PREV_RST = 1'b0;

  // ------------------------------------------------------------------
  // reset sequencer states, gray along hold, stretch, run
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_HOLD    = 2'h0,
    ST_STRETCH = 2'h1,
    ST_RUN     = 2'h3
  } sup_state_e;

endpackage

// File: verilog/interval_timer.sv
// up-counter that saturates at a limit and reports completion
`timescale 1ns/100ps
module interval_timer #(
  parameter int unsigned WIDTH = 27,
  parameter logic [WIDTH-1:0] LIMIT = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // control
  input wire logic clear_i,
  input wire logic run_i,
  // status
  output logic done_o,
  output logic [WIDTH-1:0] count_o
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  // holds at limit minus one so done stays a level
  assign done_o = (count_q == (LIMIT - WIDTH'(1)));
  assign count_o = count_q;

  always_comb begin
    count_d = count_q;
    if (clear_i) begin
      count_d = '0;
    end else if (run_i && !done_o) begin
      count_d = count_q + WIDTH'(1);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule

// File: verilog/supply_supervisor_watchdog.sv
// supply supervisor: reset stretcher, manual reset, watchdog, power fail
//
// Function
// - reset held while supply below threshold
// - reset stays 200 ms after supply recovers
// - brownout activates reset, 200 ms after recovery
// - new interruption restarts full 200 ms stretch
// - reset active high, low, or complementary both
// - manual low triggers reset at once, no debounce; held 200 ms after release
// - manual input high never resets; floating needs an external pull-up
// - no kick for 1.6 s drives watchdog low
// - both kick edges clear the watchdog counter
// - kick pulses down to 50 ns detected
// - watchdog counter held clear during reset
// - supply low forces watchdog output low
// - watchdog low until cleared, high on recovery
// - watchdog timeout alone never drives reset
// - power fail output low while sense low
`timescale 1ns/100ps
module supply_supervisor_watchdog #(
  parameter int unsigned CLK_HZ = supervisor_pkg::CLK_HZ,
  parameter int unsigned TIMER_W = supervisor_pkg::TIMER_W,
  parameter bit HAS_WATCHDOG = 1'b1,
  parameter bit RESET_ACTIVE_HIGH = 1'b0,
  parameter logic [TIMER_W-1:0] STRETCH_CYCLES = TIMER_W'(
    longint'(CLK_HZ) / supervisor_pkg::CLK_PER_MS *
    supervisor_pkg::STRETCH_MS),
  parameter logic [TIMER_W-1:0] WDOG_CYCLES = TIMER_W'(
    longint'(CLK_HZ) / supervisor_pkg::CLK_PER_MS *
    supervisor_pkg::WDOG_TIMEOUT_MS)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // monitored conditions, already synchronous
  input wire logic supply_low_i,
  input wire logic power_fail_sense_low_i,
  // processor side inputs
  input wire logic manual_reset_n_i,
  input wire logic watchdog_kick_i,
  // processor side outputs
  output logic reset_o,
  output logic reset_n_o,
  output logic watchdog_expired_n_o,
  output logic power_fail_n_o
);

  // ------------------------------------------------------------------
  // reset triggers
  // ------------------------------------------------------------------
  logic trigger;
  logic manual_low;

  // only a low level counts; a tied or pulled-up input idles high
  assign manual_low = !manual_reset_n_i;
  // watchdog state is not a trigger; it only reaches reset externally
  assign trigger = supply_low_i || manual_low;

  // ------------------------------------------------------------------
  // reset sequencer
  // ------------------------------------------------------------------
  supervisor_pkg::sup_state_e state_q;
  supervisor_pkg::sup_state_e state_d;
  logic stretch_done;
  logic stretch_clear;
  logic [TIMER_W-1:0] stretch_count;

  // counter restarts from zero whenever the stretch is left
  assign stretch_clear = (state_q != supervisor_pkg::ST_STRETCH);

  interval_timer #(
    .WIDTH(TIMER_W),
    .LIMIT(STRETCH_CYCLES)
  ) u_stretch_timer (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(stretch_clear),
    .run_i(1'b1),
    .done_o(stretch_done),
    .count_o(stretch_count)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      supervisor_pkg::ST_HOLD: begin
        // held while supply low or manual input low
        if (!trigger) begin
          state_d = supervisor_pkg::ST_STRETCH;
        end
      end
      supervisor_pkg::ST_STRETCH: begin
        if (trigger) begin
          state_d = supervisor_pkg::ST_HOLD;
        end else if (stretch_done) begin
          state_d = supervisor_pkg::ST_RUN;
        end
      end
      supervisor_pkg::ST_RUN: begin
        if (trigger) begin
          state_d = supervisor_pkg::ST_HOLD;
        end
      end
      default: begin
        state_d = supervisor_pkg::ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= supervisor_pkg::ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------------
  // reset outputs
  // ------------------------------------------------------------------
  logic rst_q;
  logic rst_d;
  logic rst_hi_q;
  logic rst_hi_d;
  logic rst_lo_n_q;
  logic rst_lo_n_d;
  logic hi_pin_used;
  logic lo_pin_used;

  // watchdog build has one reset pin; the other build drives both
  assign hi_pin_used = !HAS_WATCHDOG || RESET_ACTIVE_HIGH;
  assign lo_pin_used = !HAS_WATCHDOG || !RESET_ACTIVE_HIGH;

  always_comb begin
    rst_d = (state_d != supervisor_pkg::ST_RUN);
    // unused pin parks at its inactive level
    rst_hi_d = hi_pin_used && rst_d;
    rst_lo_n_d = !(lo_pin_used && rst_d);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_q <= supervisor_pkg::RESET_ACTIVE_RST;
      rst_hi_q <= (!HAS_WATCHDOG || RESET_ACTIVE_HIGH);
      rst_lo_n_q <= !(!HAS_WATCHDOG || !RESET_ACTIVE_HIGH);
    end else begin
      rst_q <= rst_d;
      rst_hi_q <= rst_hi_d;
      rst_lo_n_q <= rst_lo_n_d;
    end
  end

  assign reset_o = rst_hi_q;
  assign reset_n_o = rst_lo_n_q;

  // ------------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------------
  logic kick_prev_q;
  logic kick_prev_d;
  logic kick_edge;
  logic wd_clear;
  logic wd_done;
  logic wd_expired;
  logic [TIMER_W-1:0] wd_count;

  // inputs are sampled each cycle, so any pulse of one cycle or more
  // is seen; 50 ns spans at least one cycle at this rate
  assign kick_edge = (watchdog_kick_i != kick_prev_q);
  // timeout window only opens once reset has let go
  assign wd_clear = kick_edge || rst_q;
  assign wd_expired = HAS_WATCHDOG && wd_done && !wd_clear;

  interval_timer #(
    .WIDTH(TIMER_W),
    .LIMIT(WDOG_CYCLES)
  ) u_watchdog_timer (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(wd_clear),
    .run_i(HAS_WATCHDOG),
    .done_o(wd_done),
    .count_o(wd_count)
  );

  always_comb begin
    kick_prev_d = watchdog_kick_i;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      kick_prev_q <= supervisor_pkg::KICK_PREV_RST;
    end else begin
      kick_prev_q <= kick_prev_d;
    end
  end

  // ------------------------------------------------------------------
  // watchdog and power fail outputs
  // ------------------------------------------------------------------
  logic wdo_n_q;
  logic wdo_n_d;
  logic pfo_n_q;
  logic pfo_n_d;

  always_comb begin
    // supply low overrides the counter; recovery releases it at once
    wdo_n_d = !(HAS_WATCHDOG && (supply_low_i || wd_expired));
    // comparator result is registered, unfiltered, one cycle late
    pfo_n_d = !power_fail_sense_low_i;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wdo_n_q <= supervisor_pkg::WDO_N_RST;
      pfo_n_q <= supervisor_pkg::PFO_N_RST;
    end else begin
      wdo_n_q <= wdo_n_d;
      pfo_n_q <= pfo_n_d;
    end
  end

  assign watchdog_expired_n_o = wdo_n_q;
  assign power_fail_n_o = pfo_n_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  logic [TIMER_W:0] since_trig_q;
  logic [TIMER_W:0] since_trig_d;

  // cycles since the last trigger, saturating
  always_comb begin
    since_trig_d = since_trig_q;
    if (trigger) begin
      since_trig_d = '0;
    end else if (since_trig_q != '1) begin
      since_trig_d = since_trig_q + (TIMER_W + 1)'(1);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      since_trig_q <= '0;
    end else begin
      since_trig_q <= since_trig_d;
    end
  end

  a_hold_supply_low: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    supply_low_i |=> rst_q && (state_q == supervisor_pkg::ST_HOLD))
    else $error("reset not held while supply low");

  a_stretch_length: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    $fell(rst_q) |->
      (since_trig_q == ({1'b0, STRETCH_CYCLES} + (TIMER_W + 1)'(1))))
    else $error("reset stretch length wrong");

  a_brownout_reset: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (state_q == supervisor_pkg::ST_RUN) && supply_low_i
      |=> rst_q ##1 rst_q)
    else $error("brownout did not assert reset");

  a_restart_stretch: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (state_q == supervisor_pkg::ST_STRETCH) && trigger
      |=> (state_q == supervisor_pkg::ST_HOLD) ##1 (stretch_count == '0))
    else $error("stretch not restarted");

  a_reset_polarity: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !HAS_WATCHDOG |-> (reset_o == !reset_n_o) && (reset_o == rst_q))
    else $error("reset outputs not complementary");

  a_manual_trigger: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !manual_reset_n_i |=> rst_q && !reset_n_o == lo_pin_used)
    else $error("manual reset ignored");

  a_manual_idle: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (state_q == supervisor_pkg::ST_RUN) && manual_reset_n_i
      && !supply_low_i |=> (state_q == supervisor_pkg::ST_RUN) && !rst_q)
    else $error("idle manual input caused reset");

  a_wdog_timeout: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    HAS_WATCHDOG && !rst_q && !kick_edge
      && (wd_count == (WDOG_CYCLES - TIMER_W'(1)))
      |=> !watchdog_expired_n_o)
    else $error("watchdog did not expire");

  a_kick_clears: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    kick_edge |=> (wd_count == '0) ##1 watchdog_expired_n_o || supply_low_i
      || $past(supply_low_i))
    else $error("kick did not clear watchdog");

  a_short_kick: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    $changed(watchdog_kick_i) ##1 $changed(watchdog_kick_i)
      |-> (wd_count == '0))
    else $error("short kick pulse missed");

  a_clear_in_reset: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    rst_q |=> (wd_count == '0))
    else $error("watchdog counted during reset");

  a_wdo_supply_low: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    HAS_WATCHDOG && supply_low_i |=> !watchdog_expired_n_o)
    else $error("watchdog output high while supply low");

  a_wdo_recovery: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    $fell(supply_low_i) |=> watchdog_expired_n_o)
    else $error("watchdog output not released on recovery");

  a_timeout_no_reset: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !watchdog_expired_n_o && !trigger && !rst_q |=> !rst_q)
    else $error("watchdog timeout drove reset");

  a_pfo_follows: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    power_fail_sense_low_i [*2] |=> !power_fail_n_o [*1] ##1
      (power_fail_n_o == !$past(power_fail_sense_low_i)))
    else $error("power fail output wrong");

endmodule

// File: tb/cpu_model.sv
// processor model: kicks the watchdog while it is out of reset
`timescale 1ns/100ps
module cpu_model (
  // clock and the reset it receives
  input wire logic clk_i,
  input wire logic cpu_reset_n_i,
  // test control
  input wire logic stall_i,
  input wire logic [7:0] period_i,
  // watchdog kick line
  output logic watchdog_kick_o
);
  int cnt = 0;

  initial watchdog_kick_o = 1'b0;

  // ------------------------------------------------------------
  // kick generator
  // ------------------------------------------------------------
  // a stalled or held processor leaves the line still
  always @(posedge clk_i) begin
    if (!cpu_reset_n_i || stall_i) begin
      cnt <= 0;
    end else if (cnt >= int'(period_i) - 1) begin
      cnt <= 0;
      watchdog_kick_o <= ~watchdog_kick_o;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// File: tb/supply_supervisor_watchdog_test.sv
// bench for the supply supervisor with a processor partner
`timescale 1ns/100ps
module supply_supervisor_watchdog_test;
  // short counts; the stretch outlasts the timeout on purpose
  localparam int S = 60;
  localparam int W = 50;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic supply_low_i = 1'b0;
  logic power_fail_sense_low_i = 1'b0;
  logic manual_reset_n_i = 1'b1;
  logic stall = 1'b0;
  logic [7:0] period = 8'h2D;
  logic watchdog_kick;
  logic reset_o;
  logic reset_n_o;
  logic watchdog_expired_n_o;
  logic power_fail_n_o;
  logic both_reset_o;
  logic both_reset_n_o;
  logic both_expired_n_o;
  logic high_reset_o;
  logic high_reset_n_o;
  logic exp_pf;
  logic was_up;
  logic act;
  int left = 0;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  int kick_cyc = 0;
  integer seed = 32'h4450;

  supply_supervisor_watchdog #(
    .STRETCH_CYCLES(27'(S)),
    .WDOG_CYCLES(27'(W))
  ) u_dut (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .supply_low_i(supply_low_i),
    .power_fail_sense_low_i(power_fail_sense_low_i),
    .manual_reset_n_i(manual_reset_n_i),
    .watchdog_kick_i(watchdog_kick),
    .reset_o(reset_o),
    .reset_n_o(reset_n_o),
    .watchdog_expired_n_o(watchdog_expired_n_o),
    .power_fail_n_o(power_fail_n_o)
  );

  supply_supervisor_watchdog #(
    .HAS_WATCHDOG(1'b0),
    .STRETCH_CYCLES(27'(S)),
    .WDOG_CYCLES(27'(W))
  ) u_both (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .supply_low_i(supply_low_i),
    .power_fail_sense_low_i(power_fail_sense_low_i),
    .manual_reset_n_i(manual_reset_n_i),
    .watchdog_kick_i(watchdog_kick),
    .reset_o(both_reset_o),
    .reset_n_o(both_reset_n_o),
    .watchdog_expired_n_o(both_expired_n_o),
    .power_fail_n_o()
  );

  // watchdog build with the active-high pin in use
  supply_supervisor_watchdog #(
    .RESET_ACTIVE_HIGH(1'b1),
    .STRETCH_CYCLES(27'(S)),
    .WDOG_CYCLES(27'(W))
  ) u_high (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .supply_low_i(supply_low_i),
    .power_fail_sense_low_i(power_fail_sense_low_i),
    .manual_reset_n_i(manual_reset_n_i),
    .watchdog_kick_i(watchdog_kick),
    .reset_o(high_reset_o),
    .reset_n_o(high_reset_n_o),
    .watchdog_expired_n_o(),
    .power_fail_n_o()
  );

  cpu_model u_cpu (
    .clk_i(clk_i),
    .cpu_reset_n_i(reset_n_o),
    .stall_i(stall),
    .period_i(period),
    .watchdog_kick_o(watchdog_kick)
  );

  always #10 clk_i = ~clk_i;

  always @(watchdog_kick) kick_cyc = cyc;

  // ------------------------------------------------------------
  // compare and report
  // ------------------------------------------------------------
  task automatic check_bit(input string what, input logic exp,
                           input logic got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  task automatic check_count(input string what, input int exp,
                             input int got);
    total_checks++;
    if (got != exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task automatic trigger(input logic manual, input logic on);
    if (manual) begin
      manual_reset_n_i = ~on;
    end else begin
      supply_low_i = on;
    end
  endtask

  // ------------------------------------------------------------
  // reference of the reset stretch, checked every cycle
  // ------------------------------------------------------------
  // watchdog state is left out of the reference on purpose
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    exp_pf = ~power_fail_sense_low_i;
    was_up = reset_n_i;
    if (!reset_n_i || supply_low_i || !manual_reset_n_i) begin
      left = S + 1;
    end else if (left != 0) begin
      left = left - 1;
    end
    act = (left != 0);
    #1;
    check_bit("reset_n_o", ~act, reset_n_o);
    check_bit("reset_o", 1'b0, reset_o);
    check_bit("both_reset_o", act, both_reset_o);
    check_bit("both_reset_n_o", ~act, both_reset_n_o);
    check_bit("both_expired_n_o", 1'b1, both_expired_n_o);
    check_bit("high_reset_o", act, high_reset_o);
    check_bit("high_reset_n_o", 1'b1, high_reset_n_o);
    if (was_up) begin
      check_bit("power_fail_n_o", exp_pf, power_fail_n_o);
    end
    power_fail_sense_low_i = 1'($random(seed));
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int len;
    repeat (2) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    tick(S + 2);
    for (int i = 0; i < 8; i++) begin
      len = 1 + $unsigned($random(seed)) % 8;
      trigger(i[0], 1'b1);
      tick(1);
      check_bit("watchdog_expired_n_o", i[0], watchdog_expired_n_o);
      tick(len);
      trigger(i[0], 1'b0);
      if (i >= 4) begin
        tick(1 + $unsigned($random(seed)) % (S - 2));
        trigger(i[0], 1'b1);
        tick(1);
        trigger(i[0], 1'b0);
      end
      tick(1);
      check_bit("watchdog_expired_n_o", 1'b1, watchdog_expired_n_o);
      tick(S + 2);
      check_bit("watchdog_expired_n_o", 1'b1, watchdog_expired_n_o);
    end
    // second reset in mid-run
    reset_n_i = 1'b0;
    tick(2);
    reset_n_i = 1'b1;
    tick(S + 2);
    for (int k = 0; k < 4; k++) begin
      period = (k == 0) ? 8'h01 : 8'h2D;
      if (k > 1) begin
        period = 8'(1 + $unsigned($random(seed)) % 45);
      end
      repeat (3 * W) begin
        tick(1);
        check_bit("kicked expired_n", 1'b1, watchdog_expired_n_o);
      end
    end
    period = 8'h2D;
    stall = 1'b1;
    len = 0;
    while (watchdog_expired_n_o !== 1'b0 && len < 200) begin
      tick(1);
      len++;
    end
    check_count("timeout cycles", W + 1, cyc - kick_cyc);
    tick(10);
    check_bit("watchdog_expired_n_o", 1'b0, watchdog_expired_n_o);
    stall = 1'b0;
    len = 0;
    while (watchdog_expired_n_o !== 1'b1 && len < 100) begin
      tick(1);
      len++;
    end
    check_count("recovery cycles", 1, cyc - kick_cyc);
    summarize();
  end
endmodule
